//--- bra_pkg.sv
package bra_pkg;

  // ****************************************************************
  // widths and geometry
  // ****************************************************************
  localparam int unsigned ADDR_W   = 32;                // byte address width on the bus
  localparam int unsigned DATA_W   = 32;                // same width on write and read side
  localparam int unsigned STRB_W   = DATA_W / 8;
  localparam int unsigned DEPTH    = 1024;              // words in the array
  localparam int unsigned WIDX_W   = 10;                // word index width
  localparam int unsigned BYTE_LSB = 2;                 // byte-within-word bits below this
  localparam int unsigned WORD_MSB = 11;                // top decoded address bit
  localparam int unsigned ID_W     = 4;
  localparam int unsigned LEN_W    = 8;
  localparam int unsigned SIZE_W   = 3;

  localparam logic [SIZE_W-1:0] SIZE_FULL = 3'h2;      // full word transfer size
  localparam logic [WIDX_W-1:0] IDX_LAST  = 10'h3ff;   // last word of the array
  localparam logic [WIDX_W-1:0] IDX_ONE   = 10'h001;
  localparam logic [LEN_W-1:0]  LEN_ONE   = 8'h01;
  localparam logic [LEN_W-1:0]  LEN_ZERO  = 8'h00;
  localparam logic [1:0]        RESP_OKAY = 2'h0;
  localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;

  // ****************************************************************
  // apb register map
  // ****************************************************************
  localparam int unsigned APB_AW = 12;
  localparam logic [APB_AW-1:0] OFS_CTRL   = 12'h000;  // mode, init select, start
  localparam logic [APB_AW-1:0] OFS_DEFVAL = 12'h004;  // default fill value
  localparam logic [APB_AW-1:0] OFS_STATUS = 12'h008;  // init state, refusal flag
  localparam logic [APB_AW-1:0] OFS_LAST   = 12'h00c;  // last accessed word index

  localparam int unsigned CTRL_MODE_BIT   = 0;         // 1: memory slave, 0: peripheral/lite
  localparam int unsigned CTRL_SEL_LSB    = 1;         // two-bit init select
  localparam int unsigned CTRL_START_BIT  = 3;         // write 1 to start a fill
  localparam int unsigned STAT_BUSY_BIT   = 0;
  localparam int unsigned STAT_DONE_BIT   = 1;
  localparam int unsigned STAT_REFUSE_BIT = 2;         // write 1 to clear
  localparam int unsigned STAT_ECC_BIT    = 3;

  localparam logic CTRL_MODE_RST = 1'b1;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [1:0] {INIT_NONE, INIT_FILE, INIT_DEFAULT, INIT_RSVD} bra_init_sel_t;
  typedef enum logic [1:0] {W_IDLE, W_DATA, W_RESP} bra_wr_state_t;
  typedef enum logic [1:0] {R_IDLE, R_FETCH, R_DATA} bra_rd_state_t;

  // ****************************************************************
  // per-location initial contents
  // ****************************************************************
  function automatic logic [DATA_W-1:0] init_content_file(input logic [WIDX_W-1:0] idx);
    logic [DATA_W-1:0] word;
    word = DATA_ZERO;
    unique case (idx)
      10'h000: word = 32'h0000_0001;
      10'h001: word = 32'h0000_0002;
      10'h002: word = 32'h0000_0004;
      10'h003: word = 32'h0000_0008;
      default: word = {22'h00_0000, idx};              // other words hold their index
    endcase
    return word;
  endfunction

endpackage

//--- bra_addr_dec.sv
`timescale 1ns/10ps
module bra_addr_dec (
  input  wire logic [bra_pkg::ADDR_W-1:0] addr_in,     // bus byte address
  input  wire logic [bra_pkg::SIZE_W-1:0] size_in,     // transfer size code
  input  wire logic                       mem_mode_in, // 1: decode low bits
  output logic [bra_pkg::WIDX_W-1:0]      widx_out,    // word index into array
  output logic [bra_pkg::ADDR_W-1:0]      next_out     // address of next beat
);

  logic [bra_pkg::SIZE_W-1:0] size_eff;
  logic [bra_pkg::ADDR_W-1:0] step;
  logic [bra_pkg::ADDR_W-1:0] mask;
  logic [bra_pkg::ADDR_W-1:0] base;

  // word index from bits above the byte lanes, upper bits dropped
  assign widx_out = addr_in[bra_pkg::WORD_MSB:bra_pkg::BYTE_LSB];

  // size capped at the word, peripheral mode forces full words
  assign size_eff = (!mem_mode_in || size_in > bra_pkg::SIZE_FULL) ? bra_pkg::SIZE_FULL : size_in;

  // incrementing beat: align to the size then step by it
  assign step = bra_pkg::ADDR_W'(1) << size_eff;
  assign mask = ~(step - bra_pkg::ADDR_W'(1));
  assign base = mem_mode_in ? (addr_in & mask) : {addr_in[bra_pkg::ADDR_W-1:bra_pkg::BYTE_LSB], 2'h0};
  assign next_out = base + step;

endmodule

//--- bra_mem.sv
`timescale 1ns/10ps
module bra_mem (
  input  wire logic                       clk_in,   // system clock
  input  wire logic                       we_in,    // write this cycle
  input  wire logic [bra_pkg::STRB_W-1:0] wstrb_in, // byte enables
  input  wire logic [bra_pkg::WIDX_W-1:0] waddr_in, // write word index
  input  wire logic [bra_pkg::DATA_W-1:0] wdata_in, // write data
  input  wire logic                       re_in,    // read this cycle
  input  wire logic [bra_pkg::WIDX_W-1:0] raddr_in, // read word index
  output logic [bra_pkg::DATA_W-1:0]      rdata_out // read data, next cycle
);

  logic [bra_pkg::DATA_W-1:0] mem_reg [bra_pkg::DEPTH];

  // byte-enabled write, same width as the read side
  always_ff @(posedge clk_in) begin
    if (we_in) begin
      for (int b = 0; b < int'(bra_pkg::STRB_W); b++) begin
        if (wstrb_in[b]) begin
          mem_reg[waddr_in][b*8 +: 8] <= wdata_in[b*8 +: 8];
        end
      end
    end
  end

  // single registered read, no extra output stage
  always_ff @(posedge clk_in) begin
    if (re_in) begin
      rdata_out <= mem_reg[raddr_in];
    end
  end

endmodule

//--- bra_top.sv
`timescale 1ns/10ps
module bra_top #(
  parameter logic [1:0]                  INIT_KIND     = 2'h0,          // reset init select
  parameter logic [bra_pkg::DATA_W-1:0]  DEFAULT_VALUE = 32'h0000_0000, // reset fill value
  parameter bit                          ECC_EN        = 1'b0           // error correction fitted
) (
  input  wire logic                        clk_in,        // 250 MHz clock
  input  wire logic                        rst_in,        // sync reset, high
  // apb
  input  wire logic [bra_pkg::APB_AW-1:0]  paddr_in,      // apb address
  input  wire logic                        psel_in,       // apb select
  input  wire logic                        penable_in,    // apb enable
  input  wire logic                        pwrite_in,     // apb direction
  input  wire logic [bra_pkg::DATA_W-1:0]  pwdata_in,     // apb write data
  output logic                             pready_out,    // apb ready
  output logic [bra_pkg::DATA_W-1:0]       prdata_out,    // apb read data
  output logic                             pslverr_out,   // apb error
  // axi write address
  input  wire logic [bra_pkg::ID_W-1:0]    awid_in,       // write id
  input  wire logic [bra_pkg::ADDR_W-1:0]  awaddr_in,     // write byte address
  input  wire logic [bra_pkg::LEN_W-1:0]   awlen_in,      // beats minus one
  input  wire logic [bra_pkg::SIZE_W-1:0]  awsize_in,     // beat size
  input  wire logic                        awvalid_in,    // address valid
  output logic                             awready_out,   // address taken
  // axi write data
  input  wire logic [bra_pkg::DATA_W-1:0]  wdata_in,      // write data
  input  wire logic [bra_pkg::STRB_W-1:0]  wstrb_in,      // byte strobes
  input  wire logic                        wlast_in,      // last beat
  input  wire logic                        wvalid_in,     // data valid
  output logic                             wready_out,    // data taken
  // axi write response
  output logic [bra_pkg::ID_W-1:0]         bid_out,       // response id
  output logic [1:0]                       bresp_out,     // always okay
  output logic                             bvalid_out,    // response valid
  input  wire logic                        bready_in,     // response taken
  // axi read address
  input  wire logic [bra_pkg::ID_W-1:0]    arid_in,       // read id
  input  wire logic [bra_pkg::ADDR_W-1:0]  araddr_in,     // read byte address
  input  wire logic [bra_pkg::LEN_W-1:0]   arlen_in,      // beats minus one
  input  wire logic [bra_pkg::SIZE_W-1:0]  arsize_in,     // beat size
  input  wire logic                        arvalid_in,    // address valid
  output logic                             arready_out,   // address taken
  // axi read data
  output logic [bra_pkg::ID_W-1:0]         rid_out,       // read id
  output logic [bra_pkg::DATA_W-1:0]       rdata_out,     // read data
  output logic [1:0]                       rresp_out,     // always okay
  output logic                             rlast_out,     // last beat
  output logic                             rvalid_out,    // data valid
  input  wire logic                        rready_in      // data taken
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  logic                         mode_reg;
  logic [1:0]                   sel_reg;
  logic [bra_pkg::DATA_W-1:0]   defval_reg;
  logic                         busy_reg;
  logic                         done_reg;
  logic                         refused_reg;
  logic                         boot_reg;
  logic [bra_pkg::WIDX_W-1:0]   init_idx_reg;
  logic [bra_pkg::WIDX_W-1:0]   last_reg;

  bra_pkg::bra_wr_state_t       w_state_reg;
  logic [bra_pkg::ADDR_W-1:0]   w_addr_reg;
  logic [bra_pkg::SIZE_W-1:0]   w_size_reg;
  logic [bra_pkg::ID_W-1:0]     w_id_reg;
  bra_pkg::bra_rd_state_t       r_state_reg;
  logic [bra_pkg::ADDR_W-1:0]   r_addr_reg;
  logic [bra_pkg::SIZE_W-1:0]   r_size_reg;
  logic [bra_pkg::LEN_W-1:0]    r_left_reg;
  logic [bra_pkg::ID_W-1:0]     r_id_reg;

  logic                         apb_wr;
  logic                         apb_setup;
  logic                         start_req;
  logic                         init_go;
  logic                         init_deny;
  logic                         idle;
  logic                         w_beat;
  logic                         r_beat;
  logic [bra_pkg::WIDX_W-1:0]   w_idx;
  logic [bra_pkg::ADDR_W-1:0]   w_next;
  logic [bra_pkg::WIDX_W-1:0]   r_idx;
  logic [bra_pkg::ADDR_W-1:0]   r_next;
  logic                         mem_we;
  logic [bra_pkg::STRB_W-1:0]   mem_strb;
  logic [bra_pkg::WIDX_W-1:0]   mem_waddr;
  logic [bra_pkg::DATA_W-1:0]   mem_wdata;

  // ****************************************************************
  // apb slave
  // ****************************************************************
  assign pready_out = 1'b1;
  assign apb_setup  = psel_in && !penable_in;
  assign apb_wr     = psel_in && penable_in && pwrite_in;

  // read data and error prepared in setup, held through access
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      prdata_out  <= bra_pkg::DATA_ZERO;
      pslverr_out <= 1'b0;
    end else if (apb_setup) begin
      pslverr_out <= 1'b0;
      prdata_out  <= bra_pkg::DATA_ZERO;
      unique case (paddr_in)
        bra_pkg::OFS_CTRL: begin
          prdata_out[bra_pkg::CTRL_MODE_BIT]                    <= mode_reg;
          prdata_out[bra_pkg::CTRL_SEL_LSB +: 2]                <= sel_reg;
        end
        bra_pkg::OFS_DEFVAL: prdata_out <= defval_reg;
        bra_pkg::OFS_STATUS: begin
          prdata_out[bra_pkg::STAT_BUSY_BIT]   <= busy_reg;
          prdata_out[bra_pkg::STAT_DONE_BIT]   <= done_reg;
          prdata_out[bra_pkg::STAT_REFUSE_BIT] <= refused_reg;
          prdata_out[bra_pkg::STAT_ECC_BIT]    <= ECC_EN;
        end
        bra_pkg::OFS_LAST: prdata_out[bra_pkg::WIDX_W-1:0] <= last_reg;
        default: pslverr_out <= 1'b1;                     // unmapped
      endcase
    end
  end

  // control and default value registers
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      mode_reg   <= bra_pkg::CTRL_MODE_RST;
      sel_reg    <= INIT_KIND;
      defval_reg <= DEFAULT_VALUE;
    end else if (apb_wr) begin
      if (paddr_in == bra_pkg::OFS_CTRL) begin
        mode_reg <= pwdata_in[bra_pkg::CTRL_MODE_BIT];
        sel_reg  <= pwdata_in[bra_pkg::CTRL_SEL_LSB +: 2];
      end
      if (paddr_in == bra_pkg::OFS_DEFVAL) begin
        defval_reg <= pwdata_in;
      end
    end
  end

  // ****************************************************************
  // content initialisation
  // ****************************************************************
  assign idle      = (w_state_reg == bra_pkg::W_IDLE) && (r_state_reg == bra_pkg::R_IDLE);
  assign start_req = boot_reg || (apb_wr && paddr_in == bra_pkg::OFS_CTRL && pwdata_in[bra_pkg::CTRL_START_BIT]);
  assign init_deny = start_req && (sel_reg != bra_pkg::INIT_NONE) && ECC_EN;
  assign init_go   = start_req && (sel_reg == bra_pkg::INIT_FILE || sel_reg == bra_pkg::INIT_DEFAULT)
                     && !ECC_EN && !busy_reg && idle;

  // one fill after reset if INIT_KIND selects file or default and ECC_EN is off, then only on request
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      boot_reg <= 1'b1;
    end else begin
      boot_reg <= 1'b0;
    end
  end

  // sweep engine, one word per cycle
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      busy_reg     <= 1'b0;
      done_reg     <= 1'b0;
      init_idx_reg <= '0;
    end else if (init_go) begin
      busy_reg     <= 1'b1;
      done_reg     <= 1'b0;
      init_idx_reg <= '0;
    end else if (busy_reg) begin
      init_idx_reg <= init_idx_reg + bra_pkg::IDX_ONE;
      if (init_idx_reg == bra_pkg::IDX_LAST) begin
        busy_reg <= 1'b0;
        done_reg <= 1'b1;
      end
    end
  end

  // refusal flag, a new refusal wins over a clear
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      refused_reg <= 1'b0;
    end else if (init_deny) begin
      refused_reg <= 1'b1;
    end else if (apb_wr && paddr_in == bra_pkg::OFS_STATUS && pwdata_in[bra_pkg::STAT_REFUSE_BIT]) begin
      refused_reg <= 1'b0;
    end
  end

  // ****************************************************************
  // address decode
  // ****************************************************************
  bra_addr_dec u_wdec (
    .addr_in     (w_addr_reg),
    .size_in     (w_size_reg),
    .mem_mode_in (mode_reg),
    .widx_out    (w_idx),
    .next_out    (w_next)
  );

  bra_addr_dec u_rdec (
    .addr_in     (r_addr_reg),
    .size_in     (r_size_reg),
    .mem_mode_in (mode_reg),
    .widx_out    (r_idx),
    .next_out    (r_next)
  );

  // ****************************************************************
  // axi write channel
  // ****************************************************************
  assign awready_out = (w_state_reg == bra_pkg::W_IDLE) && !busy_reg && !init_go;
  assign wready_out  = (w_state_reg == bra_pkg::W_DATA);
  assign bvalid_out  = (w_state_reg == bra_pkg::W_RESP);
  assign bresp_out   = bra_pkg::RESP_OKAY;
  assign bid_out     = w_id_reg;
  assign w_beat      = wready_out && wvalid_in;

  // write burst sequencing
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      w_state_reg <= bra_pkg::W_IDLE;
      w_addr_reg  <= '0;
      w_size_reg  <= bra_pkg::SIZE_FULL;
      w_id_reg    <= '0;
    end else begin
      unique case (w_state_reg)
        bra_pkg::W_IDLE: begin
          if (awvalid_in && awready_out) begin
            w_addr_reg  <= awaddr_in;
            w_size_reg  <= awsize_in;
            w_id_reg    <= awid_in;
            w_state_reg <= bra_pkg::W_DATA;
          end
        end
        bra_pkg::W_DATA: begin
          if (w_beat) begin
            w_addr_reg <= w_next;
            if (wlast_in) begin
              w_state_reg <= bra_pkg::W_RESP;
            end
          end
        end
        bra_pkg::W_RESP: begin
          if (bready_in) begin
            w_state_reg <= bra_pkg::W_IDLE;
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // axi read channel
  // ****************************************************************
  assign arready_out = (r_state_reg == bra_pkg::R_IDLE) && !busy_reg && !init_go;
  assign rvalid_out  = (r_state_reg == bra_pkg::R_DATA);
  assign rlast_out   = rvalid_out && (r_left_reg == bra_pkg::LEN_ZERO);
  assign rresp_out   = bra_pkg::RESP_OKAY;
  assign rid_out     = r_id_reg;
  assign r_beat      = rvalid_out && rready_in;

  // read burst sequencing
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      r_state_reg <= bra_pkg::R_IDLE;
      r_addr_reg  <= '0;
      r_size_reg  <= bra_pkg::SIZE_FULL;
      r_left_reg  <= bra_pkg::LEN_ZERO;
      r_id_reg    <= '0;
    end else begin
      unique case (r_state_reg)
        bra_pkg::R_IDLE: begin
          if (arvalid_in && arready_out) begin
            r_addr_reg  <= araddr_in;
            r_size_reg  <= arsize_in;
            r_left_reg  <= arlen_in;
            r_id_reg    <= arid_in;
            r_state_reg <= bra_pkg::R_FETCH;
          end
        end
        bra_pkg::R_FETCH: r_state_reg <= bra_pkg::R_DATA;
        bra_pkg::R_DATA: begin
          if (r_beat) begin
            if (r_left_reg == bra_pkg::LEN_ZERO) begin
              r_state_reg <= bra_pkg::R_IDLE;
            end else begin
              r_addr_reg  <= r_next;
              r_left_reg  <= r_left_reg - bra_pkg::LEN_ONE;
              r_state_reg <= bra_pkg::R_FETCH;
            end
          end
        end
        default: r_state_reg <= bra_pkg::R_IDLE;           // unused code
      endcase
    end
  end

  // last word touched, shown in the last-index register
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      last_reg <= '0;
    end else if (w_beat) begin
      last_reg <= w_idx;
    end else if (r_state_reg == bra_pkg::R_FETCH) begin
      last_reg <= r_idx;
    end
  end

  // ****************************************************************
  // array and its write mux
  // ****************************************************************
  // fill sweep owns the write port while busy
  always_comb begin
    mem_we    = w_beat;
    mem_strb  = wstrb_in;
    mem_waddr = w_idx;
    mem_wdata = wdata_in;
    if (busy_reg) begin
      mem_we    = 1'b1;
      mem_strb  = '1;
      mem_waddr = init_idx_reg;
      mem_wdata = (sel_reg == bra_pkg::INIT_FILE) ? bra_pkg::init_content_file(init_idx_reg)
                                                  : defval_reg;
    end
  end

  bra_mem u_mem (
    .clk_in    (clk_in),
    .we_in     (mem_we),
    .wstrb_in  (mem_strb),
    .waddr_in  (mem_waddr),
    .wdata_in  (mem_wdata),
    .re_in     (r_state_reg == bra_pkg::R_FETCH),
    .raddr_in  (r_idx),
    .rdata_out (rdata_out)
  );

endmodule

//--- bra_monitor.sv
`timescale 1ns/10ps
module bra_monitor (
  input wire logic        clk_in, rst_in, awvalid_in, awready_out, wvalid_in, wready_out, wlast_in,
  input wire logic        bvalid_out, arvalid_in, arready_out, rvalid_out, rready_in, rlast_out,
  input wire logic [1:0]  bresp_out, rresp_out,
  input wire logic [7:0]  arlen_in,
  input wire logic [3:0]  arid_in, rid_out,
  input wire logic [31:0] rdata_out
);
  // ****************************************************************
  // axi port relations
  // ****************************************************************
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  wire ar_hs = arvalid_in && arready_out;
  rd_no_pipe_a: assert property (ar_hs |=> !rvalid_out ##1 rvalid_out) else $error("read data timing off");
  rd_len_last_a: assert property (ar_hs && arlen_in == 8'h00 |=> ##1 rlast_out) else $error("no last");
  rd_id_echo_a: assert property (ar_hs |=> ##1 rid_out == $past(arid_in, 2)) else $error("read id wrong");
  rd_hold_a: assert property (rvalid_out && !rready_in |=> rvalid_out && $stable(rdata_out)) else $error("r drop");
  rd_no_fault_a: assert property (rvalid_out |-> rresp_out == 2'h0) else $error("read fault");
  wr_no_fault_a: assert property (bvalid_out |-> bresp_out == 2'h0) else $error("write fault");
  wr_take_a: assert property (awvalid_in && awready_out |=> wready_out) else $error("no wready");
  wr_resp_a: assert property (wvalid_in && wready_out && wlast_in |=> bvalid_out) else $error("no bvalid");
  cover property (ar_hs && arlen_in != 8'h00);
  cover property (rvalid_out && !rready_in);
  cover property (wvalid_in && wready_out && wlast_in);
endmodule
bind bra_top bra_monitor i_mon (.*);

//--- bra_axi_master.sv
`timescale 1ns/10ps
module bra_axi_master (
  input wire logic        clk_in, slow_in, awready_out, wready_out, bvalid_out, arready_out, rvalid_out,
  input wire logic [31:0] rdata_out,
  output logic            awvalid_in, wvalid_in, wlast_in, bready_in, arvalid_in, rready_in,
  output logic [3:0]      awid_in, arid_in, wstrb_in,
  output logic [7:0]      awlen_in, arlen_in,
  output logic [2:0]      awsize_in, arsize_in,
  output logic [31:0]     awaddr_in, araddr_in, wdata_in
);
  logic        rdy;
  logic [31:0] got [8];
  // idle values, full 32-bit address driven
  initial begin
    {awvalid_in, wvalid_in, wlast_in, arvalid_in} = 4'h0;
    {awid_in, arid_in, wstrb_in, awlen_in, arlen_in, awsize_in, arsize_in} = 34'h0;
    {awaddr_in, araddr_in, wdata_in} = 96'h0;
    rdy = 1'b1;
  end
  // ready every cycle, or every other cycle when slow
  always @(posedge clk_in) rdy <= !slow_in || !rdy;
  assign bready_in = rdy;
  assign rready_in = rdy;
  // burst write of n words d, d+1, ...
  task automatic wr(input logic [31:0] a, d, input int n);
    {awaddr_in, awlen_in, awsize_in, awid_in, awvalid_in} <= {a, 8'(n - 1), 3'h2, 4'h3, 1'b1};
    do @(posedge clk_in); while (!awready_out);
    awvalid_in <= 1'b0;
    awaddr_in <= ~a;
    for (int i = 0; i < n; i++) begin
      {wdata_in, wstrb_in, wlast_in, wvalid_in} <= {d + i, 4'hf, i == n - 1, 1'b1};
      do @(posedge clk_in); while (!wready_out);
    end
    wvalid_in <= 1'b0;
    wdata_in <= ~wdata_in;
    do @(posedge clk_in); while (!(bvalid_out && bready_in));
  endtask
  // burst read of n words into got
  task automatic rd(input logic [31:0] a, input int n, input logic [2:0] sz = 3'h2);
    {araddr_in, arlen_in, arsize_in, arid_in, arvalid_in} <= {a, 8'(n - 1), sz, 4'h5, 1'b1};
    do @(posedge clk_in); while (!arready_out);
    arvalid_in <= 1'b0;
    araddr_in <= ~a;
    for (int i = 0; i < n; i++) begin
      do @(posedge clk_in); while (!(rvalid_out && rready_in));
      got[i] = rdata_out;
    end
  endtask
endmodule

//--- tb_top.sv
`timescale 1ns/10ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin fail_count++; $display("Error %0t got %h exp %h", $time, g, e); end end
module tb_top;
  logic        clk_in, rst_in, psel_in, penable_in, pwrite_in, pready_out, pslverr_out, slow_in;
  logic        awvalid_in, awready_out, wlast_in, wvalid_in, wready_out, bvalid_out, bready_in;
  logic        arvalid_in, arready_out, rlast_out, rvalid_out, rready_in;
  logic [11:0] paddr_in;
  logic [31:0] pwdata_in, prdata_out, awaddr_in, wdata_in, araddr_in, rdata_out, q;
  logic [3:0]  awid_in, wstrb_in, bid_out, arid_in, rid_out;
  logic [7:0]  awlen_in, arlen_in;
  logic [2:0]  awsize_in, arsize_in;
  logic [1:0]  bresp_out, rresp_out;
  int          fail_count, total_checks;
  bra_top #(.DEFAULT_VALUE(32'h1234_5678)) i_dut (.*);
  bra_axi_master i_mst (.*);
  // ****************************************************************
  // bus tasks
  // ****************************************************************
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    {psel_in, paddr_in, pwrite_in, pwdata_in} <= {1'b1, a, w, d};
    @(posedge clk_in);
    penable_in <= 1'b1;
    do @(posedge clk_in); while (!pready_out);
    q = prdata_out;
    {psel_in, penable_in} <= 2'h0;
    @(posedge clk_in);
  endtask
  task automatic wait_idle;
    repeat (500) begin
      apb(12'h008, 1'b0, 32'h0);
      if (q[0] === 1'b0) return;
    end
    fail_count++;
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_regs;
    apb(12'h004, 1'b0, 32'h0);
    `CHK(q, 32'h1234_5678)
    apb(12'h004, 1'b1, 32'h5a5a_a5a5);
    apb(12'h040, 1'b0, 32'h0);
    `CHK({pslverr_out, q}, {1'b1, 32'h0})
  endtask
  task automatic t_alias;
    i_mst.wr(32'h0000_0ffc, 32'h0000_a000, 2);
    i_mst.rd(32'hf000_0ffc, 1);
    `CHK(i_mst.got[0], 32'h0000_a000)
    i_mst.rd(32'h0000_0000, 1);
    `CHK(i_mst.got[0], 32'h0000_a001)
    i_mst.wr(32'h0000_1008, 32'h0000_b000, 1);
    i_mst.rd(32'h0000_0004, 2);
    `CHK(i_mst.got[1], 32'h0000_b000)
    apb(12'h00c, 1'b0, 32'h0);
    `CHK(q, 32'h0000_0002)
  endtask
  task automatic t_default;
    // select is taken from the register, so it is written before the start
    apb(12'h000, 1'b1, 32'h0000_0005);
    apb(12'h000, 1'b1, 32'h0000_000d);
    wait_idle();
    `CHK(q[1:0], 2'h2)
    slow_in <= 1'b1;
    i_mst.rd(32'h0000_0600, 4);
    for (int i = 0; i < 4; i++) `CHK(i_mst.got[i], 32'h5a5a_a5a5)
    slow_in <= 1'b0;
  endtask
  task automatic t_file;
    apb(12'h000, 1'b1, 32'h0000_0003);
    apb(12'h000, 1'b1, 32'h0000_000b);
    wait_idle();
    `CHK(q[1:0], 2'h2)
    i_mst.rd(32'h0000_0000, 5);
    for (int i = 0; i < 4; i++) `CHK(i_mst.got[i], 32'h0000_0001 << i)
    `CHK(i_mst.got[4], 32'h0000_0004)
    // half-word burst: memory mode stays in word 0, peripheral mode steps a word
    i_mst.rd(32'h0000_0000, 2, 3'h1);
    `CHK(i_mst.got[1], 32'h0000_0001)
    apb(12'h000, 1'b1, 32'h0000_0002);
    i_mst.rd(32'h0000_0000, 2, 3'h1);
    `CHK(i_mst.got[1], 32'h0000_0002)
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // clock, reset and sequence
  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end
  initial begin
    {rst_in, psel_in, penable_in, pwrite_in, slow_in, paddr_in, pwdata_in} = {1'b1, 4'h0, 12'h000, 32'h0};
    repeat (3) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    t_regs();
    t_alias();
    t_default();
    t_file();
    results();
  end
  // watchdog
  initial begin
    repeat (30000) @(posedge clk_in);
    fail_count++;
    results();
  end
endmodule
